//--- bench/host_model.sv
// Host side model that serves the watchdog over the plain register port.
// Assumes read data stand in the cycle after the read strobe; no wait states.
`timescale 1ns/1ps
module host_model
	import wdg_pkg::*;
(
	input  wire logic       mclk,    // Clock
	output reg_req_t        req,     // Register request
	input  wire logic [7:0] rd_data  // Read data
);
	// Released bus shows inverted address and data so stale values never pass
	task automatic idle();
		req <= '{addr: ~req.addr, wdata: ~req.wdata, wr: 1'h0, rd: 1'h0};
	endtask : idle

	// One write cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge mclk);
		idle();
	endtask : wr

	// One read cycle, data taken in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge mclk);
		idle();
		#1 d = rd_data;
	endtask : rd

	// Serve after a delay; a bad answer flips the lowest bit
	task automatic serve(input int dly, input logic good);
		logic [7:0] q;
		repeat (dly) @(posedge mclk);
		rd(A_WD_QUES, q);
		wr(A_WD_ANS, good ? ~q : (~q ^ 8'h01));
	endtask : serve

	initial req = '{addr: 4'h0, wdata: 8'h00, wr: 1'h0, rd: 1'h0};
endmodule : host_model

//--- bench/testbench.sv
// Self-checking bench for the question-and-answer watchdog.
// Assumes a short time base tick of 4 cycles to keep periods small.
`timescale 1ns/1ps
module testbench
	import wdg_pkg::*;
;
	logic       mclk;
	logic       rst_b;
	reg_req_t   req;
	logic [7:0] rd_data;
	dev_mode_t  dev_mode;
	logic       serial_failure_flag;
	logic       special_boot_sequence;
	logic [7:0] irq_event;
	logic       fail_inc;
	logic       rxd_n;
	logic [7:0] q;
	logic [7:0] v;
	int         fail_count = 0;
	int         tests_run  = 0;
	int         fi_cnt     = 0;
	int         n;

	qa_watchdog #(.TICK_CYCLES(4), .PER_BASE(8)) i_qa_watchdog (
		.mclk(mclk), .rst_b(rst_b), .req(req), .rd_data(rd_data), .dev_mode(dev_mode),
		.serial_failure_flag(serial_failure_flag), .special_boot_sequence(special_boot_sequence),
		.irq_event(irq_event), .fail_inc(fail_inc), .rxd_n(rxd_n));
	host_model i_host_model (.mclk(mclk), .req(req), .rd_data(rd_data));

	// Clock and time-zero values
	initial begin
		mclk = 1'h0;
		rst_b = 1'h0;
		dev_mode = MODE_RESET;
		serial_failure_flag = 1'h0;
		special_boot_sequence = 1'h0;
		irq_event = 8'h00;
	end
	always #5 mclk = ~mclk;

	// Count fail-count requests
	always @(posedge mclk) if (fail_inc === 1'h1) fi_cnt <= fi_cnt + 1;

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk1

	// Read a register and compare the masked value
	task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] r;
		i_host_model.rd(a, r);
		chk8(r & m, e);
	endtask : rdchk

	// Receive pin after it has settled
	task automatic pin_chk(input logic e);
		repeat (3) @(posedge mclk);
		#1 chk1(rxd_n, e);
	endtask : pin_chk

	task automatic do_reset(input dev_mode_t m);
		@(posedge mclk) rst_b <= 1'h0;
		dev_mode <= MODE_RESET;
		repeat (2) @(posedge mclk);
		rst_b <= 1'h1;
		@(posedge mclk) dev_mode <= m;
		@(posedge mclk);
	endtask : do_reset

	task automatic pulse(input logic [7:0] e);
		@(posedge mclk) irq_event <= e;
		@(posedge mclk) irq_event <= 8'h00;
	endtask : pulse

	task automatic t_regs();
		do_reset(MODE_RESET);
		rdchk(A_WD_CFG, 8'hFF, 8'h04);
		rdchk(A_WD_STAT, 8'hFF, 8'h02);
		rdchk(A_IRQ_ST, 8'hFF, 8'h01);
		rdchk(A_IRQ_EN, 8'hFF, 8'h03);
		rdchk(A_WD_ANS, 8'hFF, 8'h00);
		rdchk(4'hF, 8'hFF, 8'h00);
	endtask : t_regs

	// Timeout mode: prompt and slow correct answers
	task automatic t_valid();
		do_reset(MODE_STANDBY);
		n = fi_cnt;
		i_host_model.rd(A_WD_QUES, q);
		i_host_model.serve(0, 1'h1);
		i_host_model.rd(A_WD_QUES, v);
		chk1(q != v, 1'h1);
		i_host_model.serve(200, 1'h1);
		rdchk(A_WD_STAT, 8'h13, 8'h02);
		chk8(8'(fi_cnt - n), 8'h00);
	endtask : t_valid

	task automatic t_wrong();
		do_reset(MODE_STANDBY);
		n = fi_cnt;
		i_host_model.serve(0, 1'h0);
		rdchk(A_WD_STAT, 8'h03, 8'h03);
		chk8(8'(fi_cnt - n), 8'h01);
		i_host_model.serve(0, 1'h0);
		rdchk(A_WD_STAT, 8'h03, 8'h03);
	endtask : t_wrong

	// Window mode: early answer refused, late answer taken
	task automatic t_window();
		dev_mode_t m;
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? MODE_NORMAL : MODE_LISTEN;
			do_reset(m);
			i_host_model.serve(0, 1'h1);
			rdchk(A_WD_STAT, 8'h03, 8'h03);
			do_reset(m);
			i_host_model.serve(300, 1'h1);
			rdchk(A_WD_STAT, 8'h13, 8'h12);
			i_host_model.serve(0, 1'h1);
			rdchk(A_WD_STAT, 8'h03, 8'h03);
		end
		do_reset(MODE_STANDBY);
		@(posedge mclk) serial_failure_flag <= 1'h1;
		i_host_model.serve(0, 1'h1);
		@(posedge mclk) serial_failure_flag <= 1'h0;
		rdchk(A_WD_STAT, 8'h03, 8'h03);
	endtask : t_window

	// Shortest period overflows, then leaving Reset reloads the counter
	task automatic t_period();
		do_reset(MODE_RESET);
		i_host_model.wr(A_WD_CFG, 8'h00);
		@(posedge mclk) dev_mode <= MODE_STANDBY;
		repeat (14) @(posedge mclk);
		rdchk(A_WD_STAT, 8'h03, 8'h02);
		repeat (30) @(posedge mclk);
		rdchk(A_WD_STAT, 8'h03, 8'h03);
		@(posedge mclk) dev_mode <= MODE_RESET;
		@(posedge mclk) dev_mode <= MODE_STANDBY;
		rdchk(A_WD_STAT, 8'h03, 8'h02);
	endtask : t_period

	task automatic t_sdm();
		do_reset(MODE_STANDBY);
		@(posedge mclk) special_boot_sequence <= 1'h1;
		@(posedge mclk) special_boot_sequence <= 1'h0;
		rdchk(A_WD_STAT, 8'h0C, 8'h04);
		i_host_model.wr(A_WD_CFG, 8'h0C);
		rdchk(A_WD_CFG, 8'h08, 8'h08);
		n = fi_cnt;
		i_host_model.wr(A_WD_ANS, 8'h00);
		rdchk(A_WD_STAT, 8'h0C, 8'h08);
		i_host_model.serve(0, 1'h0);
		i_host_model.serve(0, 1'h0);
		rdchk(A_WD_STAT, 8'h03, 8'h03);
		chk8(8'(fi_cnt - n), 8'h00);
		i_host_model.wr(A_WD_CFG, 8'h04);
		i_host_model.wr(A_WD_CFG, 8'h0C);
		rdchk(A_WD_CFG, 8'h08, 8'h00);
	endtask : t_sdm

	task automatic t_off();
		do_reset(MODE_STANDBY);
		i_host_model.wr(A_WD_CFG, 8'h14);
		rdchk(A_WD_CFG, 8'h10, 8'h00);
		i_host_model.wr(A_IRQ_ST, 8'h01);
		i_host_model.wr(A_WD_CFG, 8'h14);
		rdchk(A_WD_CFG, 8'h10, 8'h10);
		rdchk(A_WD_STAT, 8'h08, 8'h00);
		pulse(8'h02);
		rdchk(A_WD_CFG, 8'h10, 8'h00);
		rdchk(A_IRQ_ST, 8'hFF, 8'h02);
		i_host_model.wr(A_IRQ_ST, 8'h02);
		i_host_model.wr(A_WD_CFG, 8'h14);
		i_host_model.wr(A_WD_ANS, 8'h00);
		rdchk(A_WD_CFG, 8'h10, 8'h00);
	endtask : t_off

	task automatic t_irq();
		do_reset(MODE_STANDBY);
		pin_chk(1'h0);
		i_host_model.wr(A_IRQ_ST, 8'h01);
		pin_chk(1'h1);
		pulse(8'h08);
		rdchk(A_IRQ_ST, 8'hFF, 8'h00);
		i_host_model.wr(A_IRQ_EN, 8'h08);
		pulse(8'h08);
		rdchk(A_IRQ_ST, 8'hFF, 8'h08);
		pin_chk(1'h1);
		i_host_model.wr(A_SYS_CFG, 8'h01);
		pin_chk(1'h0);
		fork
			i_host_model.wr(A_IRQ_ST, 8'h08);
			pulse(8'h08);
		join
		rdchk(A_IRQ_ST, 8'hFF, 8'h08);
		@(posedge mclk) dev_mode <= MODE_NORMAL;
		pin_chk(1'h1);
		@(posedge mclk) dev_mode <= MODE_SLEEP;
		pin_chk(1'h0);
		i_host_model.wr(A_IRQ_ST, 8'h08);
		rdchk(A_IRQ_ST, 8'hFF, 8'h00);
		pin_chk(1'h1);
	endtask : t_irq

	// Main sequence
	initial begin
		t_regs();
		t_valid();
		t_wrong();
		t_window();
		t_period();
		t_sdm();
		t_off();
		t_irq();
		conclude();
	end

	// Hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		#300000;
		fail_count++;
		conclude();
	end
endmodule : testbench

//--- inc/wdg_pkg.sv
// Constants, types and register map of the question-and-answer watchdog.
// Assumes a single 100 MHz clock and byte-wide registers on a plain port.
// Overview of operation
// - Normal or ListenOnly mode: window mode, answer taken in second half only.
// - Standby mode: timeout mode, correct answer accepted any time in period.
// - Period length chosen by a select field in the watchdog config register.
// - In Standby, disable bit set to 1 is honoured only with nothing pending.
// - New interrupt or answer write re-activates watchdog, clears disable bit.
// - Valid trigger needs answer equal to bitwise inverse of question.
// - Answer counts only if its serial transfer had no failure flag.
// - Invalid: wrong answer, period overflow, or early answer in window mode.
// - Every valid or invalid trigger restarts timer and makes a new question.
// - Fail counter loaded with 2 when device leaves Reset mode.
// - Each invalid trigger increments fail counter, saturating at 3.
// - Counter 3 after increment and debug bit clear: enter fail-count state.
// - Development mode entered only by special boot sequence; watchdog idle.
// - Development mode status readable in watchdog status register.
// - Outside development mode debug bit may be cleared but never set.
// - Any answer write clears development mode and resumes the watchdog.
// - Debug bit at 1 keeps bad serving from starting the reset process.
// - Standby/Sleep: receive pin low on wake/power-on, or any, per select.
// - Each source has its enable; power-on and frame-error always enabled.
// - Status bits clear by writing 1; the raising condition is untouched.
// - Set and clear in one cycle: set wins, bit stays 1.
package wdg_pkg;

	// Timing
	localparam int CLK_NS   = 10;                  // Clock period, ns
	localparam int TICK_NS  = 1000000;             // Watchdog time base, ns
	localparam int TICK_CYC = TICK_NS / CLK_NS;    // Cycles per time base tick

	// Register offsets
	localparam logic [3:0] A_WD_CFG  = 4'h0;
	localparam logic [3:0] A_WD_QUES = 4'h1;
	localparam logic [3:0] A_WD_ANS  = 4'h2;
	localparam logic [3:0] A_WD_STAT = 4'h3;
	localparam logic [3:0] A_IRQ_ST  = 4'h4;
	localparam logic [3:0] A_IRQ_EN  = 4'h5;
	localparam logic [3:0] A_SYS_CFG = 4'h6;

	// Field positions
	localparam int CFG_PER_LSB = 0;                // Three-bit period select
	localparam int CFG_DBG     = 3;                // Debug bit
	localparam int CFG_OFF     = 4;                // Disable bit
	localparam int ST_FC_LSB   = 0;                // Two-bit fail counter
	localparam int ST_SDM      = 2;                // Development mode status
	localparam int ST_RUN      = 3;                // Watchdog running
	localparam int ST_WIN      = 4;                // Window mode active
	localparam int SYS_RXD_SEL = 0;                // Receive pin irq select
	localparam int IRQ_PO      = 0;                // Power-on
	localparam int IRQ_FDE     = 1;                // Frame detect error
	localparam int IRQ_WAKE    = 2;                // Wake-up

	// Values
	localparam logic [7:0] IRQ_ALWAYS   = 8'h03;   // Sources without enable
	localparam logic [7:0] IRQ_WAKE_MSK = 8'h05;   // Wake-up and power-on
	localparam logic [7:0] IRQ_ALL_MSK  = 8'hFF;
	localparam logic [7:0] IRQ_STAT_RST = 8'h01;   // Power-on pending
	localparam logic [7:0] IRQ_EN_RST   = 8'h00;
	localparam logic [2:0] PER_SEL_RST  = 3'h4;
	localparam logic [1:0] FC_INIT      = 2'h2;
	localparam logic [1:0] FC_MAX       = 2'h3;
	localparam logic [7:0] Q_SEED       = 8'hA5;
	localparam logic [7:0] LFSR_TAPS    = 8'hB8;   // Maximal length, 255 states

	typedef enum logic [2:0] {
		MODE_RESET   = 3'h0,
		MODE_STANDBY = 3'h1,
		MODE_NORMAL  = 3'h2,
		MODE_LISTEN  = 3'h3,
		MODE_SLEEP   = 3'h4
	} dev_mode_t;

	// Gray along halt, run, off, development
	typedef enum logic [1:0] {
		WD_HALT = 2'h0,
		WD_RUN  = 2'h1,
		WD_OFF  = 2'h3,
		WD_SDM  = 2'h2
	} wd_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		wd_state_t   wst;
		dev_mode_t   mode_d;
		logic [16:0] tick_cnt;
		logic [15:0] timer;
		logic [7:0]  question;
		logic [2:0]  period_sel;
		logic        debug;
		logic [1:0]  fail_cnt;
		logic        fail_inc;
		logic [7:0]  irq_status;
		logic [7:0]  irq_en;
		logic        rxd_sel;
		logic        rxd_n;
		logic [7:0]  rd_data;
	} core_state_t;

	localparam core_state_t CORE_RST = '{
		wst: WD_HALT, mode_d: MODE_RESET, tick_cnt: 17'h00000,
		timer: 16'h0000, question: Q_SEED, period_sel: PER_SEL_RST,
		debug: 1'h0, fail_cnt: FC_INIT, fail_inc: 1'h0,
		irq_status: IRQ_STAT_RST, irq_en: IRQ_EN_RST, rxd_sel: 1'h0,
		rxd_n: 1'h1, rd_data: 8'h00};

endpackage : wdg_pkg

//--- rtl/qa_watchdog.sv
// Question-and-answer watchdog with interrupt flags and receive pin signalling.
// Assumes all inputs come from logic on mclk; events are one-cycle pulses.
`timescale 1ns/1ps
module qa_watchdog
	import wdg_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC, // Cycles per time base tick
	parameter int unsigned PER_BASE    = 8         // Ticks of shortest period
) (
	input  wire logic       mclk,                  // Clock, 100 MHz
	input  wire logic       rst_b,                 // Async reset, active low
	input  wire reg_req_t   req,                   // Register request
	output logic [7:0]      rd_data,               // Read data, next cycle
	input  wire dev_mode_t  dev_mode,              // Device operating mode
	input  wire logic       serial_failure_flag,   // Transfer in error
	input  wire logic       special_boot_sequence, // Boot sequence seen, pulse
	input  wire logic [7:0] irq_event,             // Source events, pulses
	output logic            fail_inc,              // Enter fail-count state, pulse
	output logic            rxd_n                  // Receive pin, low on selected irq in Standby/Sleep
);

	core_state_t s_r;
	core_state_t s_nxt;
	logic        wr_cfg;
	logic        wr_ans;
	logic        wr_ist;
	logic        wr_ien;
	logic        wr_sys;
	logic        stby_mode;
	logic        win_mode;
	logic        act_mode;
	logic        running;
	logic        sdm_on;
	logic        tick;
	logic        expire;
	logic        early;
	logic        ans_ok;
	logic        trig;
	logic        invalid;
	logic        leave_reset;
	logic        off_ok;
	logic [7:0]  irq_en_eff;
	logic [7:0]  irq_set;
	logic [7:0]  irq_clr;
	logic [7:0]  rxd_msk;
	logic [15:0] period;
	logic [7:0]  q_next;

	// Write decode
	assign wr_cfg = req.wr && (req.addr == A_WD_CFG);
	assign wr_ans = req.wr && (req.addr == A_WD_ANS);
	assign wr_ist = req.wr && (req.addr == A_IRQ_ST);
	assign wr_ien = req.wr && (req.addr == A_IRQ_EN);
	assign wr_sys = req.wr && (req.addr == A_SYS_CFG);

	// Mode classification
	assign stby_mode = (dev_mode == MODE_STANDBY);
	assign win_mode  = (dev_mode == MODE_NORMAL) || (dev_mode == MODE_LISTEN);
	assign act_mode  = stby_mode || win_mode;
	assign running   = (s_r.wst == WD_RUN);
	assign sdm_on    = (s_r.wst == WD_SDM);
	assign leave_reset = (s_r.mode_d == MODE_RESET) && (dev_mode != MODE_RESET);

	// Period from select field, in ticks
	assign period = 16'(PER_BASE) << s_r.period_sel;
	assign tick   = (s_r.tick_cnt == 17'(TICK_CYCLES - 1));
	assign expire = running && tick && (s_r.timer >= (period - 16'h0001));

	// Early answer only matters in window mode
	assign early  = win_mode && (s_r.timer < (period >> 1));

	// Answer check: inverse of question, clean transfer, right time
	assign ans_ok = (req.wdata == ~s_r.question)
		&& !serial_failure_flag
		&& !early;

	// Any answer or overflow while running is a trigger
	assign trig    = running && (wr_ans || expire);
	assign invalid = running && (wr_ans ? !ans_ok : expire);

	// Interrupt enables and set/clear terms
	assign irq_en_eff = s_r.irq_en | IRQ_ALWAYS;
	assign irq_set    = irq_event & irq_en_eff;
	assign irq_clr    = wr_ist ? req.wdata : 8'h00;

	// Disable request allowed only quiet and in Standby
	assign off_ok = stby_mode && (s_r.irq_status == 8'h00) && (irq_set == 8'h00);

	// Galois shift register for the next question
	assign q_next = {1'h0, s_r.question[7:1]} ^ (s_r.question[0] ? LFSR_TAPS : 8'h00);

	// Receive pin source selection
	assign rxd_msk = s_r.rxd_sel ? IRQ_ALL_MSK : IRQ_WAKE_MSK;

	// Next state of the whole block
	always_comb begin
		logic restart;
		restart = 1'h0;
		s_nxt = s_r;
		s_nxt.mode_d = dev_mode;
		s_nxt.fail_inc = 1'h0;
		s_nxt.rd_data = 8'h00;

		// Time base divider
		if (tick) begin
			s_nxt.tick_cnt = 17'h00000;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 17'h00001;
		end

		// Watchdog timer counts ticks while running
		if (running && tick) begin
			s_nxt.timer = s_r.timer + 16'h0001;
		end

		// Configuration writes
		if (wr_cfg) begin
			s_nxt.period_sel = req.wdata[CFG_PER_LSB +: 3];
			s_nxt.debug = req.wdata[CFG_DBG] && (sdm_on || s_r.debug);
		end
		if (wr_ien) begin
			s_nxt.irq_en = req.wdata & ~IRQ_ALWAYS;
		end
		if (wr_sys) begin
			s_nxt.rxd_sel = req.wdata[SYS_RXD_SEL];
		end

		// Write one to clear; a new event in the same cycle wins
		s_nxt.irq_status = (s_r.irq_status & ~irq_clr) | irq_set;

		// Watchdog state machine
		case (s_r.wst)
			WD_HALT: begin
				if (act_mode) begin
					s_nxt.wst = WD_RUN;
					restart = 1'h1;
				end
			end
			WD_RUN: begin
				if (!act_mode) begin
					s_nxt.wst = WD_HALT;
					s_nxt.timer = 16'h0000;
				end else if (trig) begin
					restart = 1'h1;
				end else if (wr_cfg && req.wdata[CFG_OFF] && off_ok) begin
					s_nxt.wst = WD_OFF;
				end
			end
			WD_OFF: begin
				if (!act_mode) begin
					s_nxt.wst = WD_HALT;
				end else if (!stby_mode || (irq_set != 8'h00) || wr_ans) begin
					s_nxt.wst = WD_RUN;
					restart = 1'h1;
				end else if (wr_cfg && !req.wdata[CFG_OFF]) begin
					s_nxt.wst = WD_RUN;
					restart = 1'h1;
				end
			end
			WD_SDM: begin
				if (wr_ans) begin
					s_nxt.wst = act_mode ? WD_RUN : WD_HALT;
					restart = 1'h1;
				end
			end
			default: begin
				s_nxt.wst = WD_HALT;
			end
		endcase

		// Development mode only from the boot sequence
		if (special_boot_sequence && !wr_ans) begin
			s_nxt.wst = WD_SDM;
		end

		// Fresh period and question
		if (restart) begin
			s_nxt.timer = 16'h0000;
			s_nxt.question = q_next;
		end

		// Fail counter, saturating
		if (invalid) begin
			if (s_r.fail_cnt != FC_MAX) begin
				s_nxt.fail_cnt = s_r.fail_cnt + 2'h1;
			end
			if ((s_r.fail_cnt >= (FC_MAX - 2'h1)) && !s_r.debug) begin
				s_nxt.fail_inc = 1'h1;
			end
		end
		if (leave_reset) begin
			s_nxt.fail_cnt = FC_INIT;
		end

		// Receive pin signals pending interrupts in low power modes
		if ((dev_mode == MODE_STANDBY) || (dev_mode == MODE_SLEEP)) begin
			s_nxt.rxd_n = ((s_r.irq_status & rxd_msk) == 8'h00);
		end else begin
			s_nxt.rxd_n = 1'h1;
		end

		// Read data, valid only in the cycle after the strobe
		if (req.rd) begin
			case (req.addr)
				A_WD_CFG: begin
					s_nxt.rd_data = {3'h0, (s_r.wst == WD_OFF), s_r.debug, s_r.period_sel};
				end
				A_WD_QUES: begin
					s_nxt.rd_data = s_r.question;
				end
				A_WD_STAT: begin
					s_nxt.rd_data = {3'h0, win_mode, running, sdm_on, s_r.fail_cnt};
				end
				A_IRQ_ST: begin
					s_nxt.rd_data = s_r.irq_status;
				end
				A_IRQ_EN: begin
					s_nxt.rd_data = irq_en_eff;
				end
				A_SYS_CFG: begin
					s_nxt.rd_data = {7'h00, s_r.rxd_sel};
				end
				default: begin
					s_nxt.rd_data = 8'h00;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= CORE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign rd_data  = s_r.rd_data;
	assign fail_inc = s_r.fail_inc;
	assign rxd_n    = s_r.rxd_n;

	// Early correct answer in window mode counts as a failure
	a_window_early: assert property (@(posedge mclk) disable iff (!rst_b)
		(running && wr_ans && win_mode && (s_r.timer < (period >> 1)) && !leave_reset
			&& (s_r.fail_cnt == 2'h2))
		|=> (s_r.fail_cnt == 2'h3))
		else $error("early answer in window mode not counted");

	// Timeout mode accepts a correct answer at once
	a_timeout_any: assert property (@(posedge mclk) disable iff (!rst_b)
		(running && wr_ans && stby_mode && (req.wdata == ~s_r.question)
			&& !serial_failure_flag && !leave_reset)
		|=> (s_r.fail_cnt == $past(s_r.fail_cnt)) && !s_r.fail_inc)
		else $error("good answer in timeout mode rejected");

	// Disable bit only taken with nothing pending
	a_off_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
		(s_r.wst != WD_OFF) ##1 (s_r.wst == WD_OFF)
		|-> ($past(s_r.irq_status) == 8'h00) && ($past(dev_mode) == MODE_STANDBY))
		else $error("watchdog disabled with interrupt pending");

	// New interrupt wakes a disabled watchdog
	a_off_wake: assert property (@(posedge mclk) disable iff (!rst_b)
		((s_r.wst == WD_OFF) && act_mode && (irq_set != 8'h00) && !special_boot_sequence)
		|=> (s_r.wst == WD_RUN) && (s_r.timer == 16'h0000))
		else $error("interrupt did not re-activate watchdog");

	// Serial failure spoils an otherwise good answer
	a_serial_failure_flag_bad: assert property (@(posedge mclk) disable iff (!rst_b)
		(running && wr_ans && serial_failure_flag && !leave_reset && (s_r.fail_cnt == 2'h2))
		|=> (s_r.fail_cnt == 2'h3))
		else $error("answer with serial failure accepted");

	// Trigger restarts the period with a new question
	a_trig_restart: assert property (@(posedge mclk) disable iff (!rst_b)
		(trig && act_mode && !special_boot_sequence)
		|=> (s_r.timer == 16'h0000) && (s_r.question != $past(s_r.question)))
		else $error("trigger did not restart watchdog");

	// Counter reloads on leaving Reset mode
	a_fc_load: assert property (@(posedge mclk) disable iff (!rst_b)
		leave_reset |=> (s_r.fail_cnt == 2'h2))
		else $error("fail counter not loaded with 2");

	// Saturation at three
	a_fc_sat: assert property (@(posedge mclk) disable iff (!rst_b)
		((s_r.fail_cnt == 2'h3) && !leave_reset) |=> (s_r.fail_cnt == 2'h3))
		else $error("fail counter left saturation");

	// Fail-count state entered at three without debug
	a_fc_enter: assert property (@(posedge mclk) disable iff (!rst_b)
		(invalid && (s_r.fail_cnt >= 2'h2) && !s_r.debug) |=> fail_inc ##1 !fail_inc)
		else $error("fail-count state not entered");

	// Debug bit blocks the fail path
	a_debug_block: assert property (@(posedge mclk) disable iff (!rst_b)
		s_r.debug |=> !fail_inc)
		else $error("fail path active with debug set");

	// Debug bit cannot be set outside development mode
	a_debug_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		(!sdm_on && !s_r.debug) |=> !s_r.debug)
		else $error("debug bit set outside development mode");

	// Answer write ends development mode
	a_sdm_exit: assert property (@(posedge mclk) disable iff (!rst_b)
		(sdm_on && wr_ans) |=> !sdm_on)
		else $error("answer write did not leave development mode");

	// Set beats clear
	a_set_wins: assert property (@(posedge mclk) disable iff (!rst_b)
		(irq_set != 8'h00) |=> ((s_r.irq_status & $past(irq_set)) == $past(irq_set)))
		else $error("interrupt event lost");

	// Receive pin follows pending interrupts in Standby
	a_rxd_level: assert property (@(posedge mclk) disable iff (!rst_b)
		(stby_mode && ((s_r.irq_status & rxd_msk) != 8'h00)) |=> !rxd_n)
		else $error("receive pin not low with interrupt pending");

	// Question read returns the question of the strobe cycle
	a_ques_read: assert property (@(posedge mclk) disable iff (!rst_b)
		(req.rd && (req.addr == A_WD_QUES))
		|=> (rd_data == $past(s_r.question)))
		else $error("question read returned wrong value");

	// Status read reports development mode
	a_sdm_status: assert property (@(posedge mclk) disable iff (!rst_b)
		(req.rd && (req.addr == A_WD_STAT))
		|=> (rd_data[ST_SDM] == $past(sdm_on)))
		else $error("development mode status misreported");

	// Written ones clear their status bits when no event collides
	a_w1c_clear: assert property (@(posedge mclk) disable iff (!rst_b)
		(wr_ist && ((irq_set & req.wdata) == 8'h00))
		|=> ((s_r.irq_status & $past(req.wdata)) == 8'h00))
		else $error("status bit not cleared by writing one");

	// Pending bits stay until software clears them
	a_w1c_keep: assert property (@(posedge mclk) disable iff (!rst_b)
		!wr_ist
		|=> ((s_r.irq_status & $past(s_r.irq_status)) == $past(s_r.irq_status)))
		else $error("status bit lost without a clear");

	// Power-on and frame error sources need no enable
	a_always_on: assert property (@(posedge mclk) disable iff (!rst_b)
		((irq_event & IRQ_ALWAYS) != 8'h00)
		|=> ((s_r.irq_status & $past(irq_event) & IRQ_ALWAYS) == ($past(irq_event) & IRQ_ALWAYS)))
		else $error("always enabled source not captured");

	// Disabled source never raises its status bit
	a_masked_src: assert property (@(posedge mclk) disable iff (!rst_b)
		(((irq_event & ~irq_en_eff) != 8'h00) && ((s_r.irq_status & ~irq_en_eff) == 8'h00))
		|=> ((s_r.irq_status & ~$past(irq_en_eff)) == 8'h00))
		else $error("disabled source raised its status bit");

	// Wrong answer counts as a failure
	a_wrong_count: assert property (@(posedge mclk) disable iff (!rst_b)
		(running && wr_ans && (req.wdata != ~s_r.question) && !leave_reset && (s_r.fail_cnt == 2'h2))
		|=> (s_r.fail_cnt == 2'h3))
		else $error("wrong answer not counted");

	// Period overflow counts as a failure
	a_expire_count: assert property (@(posedge mclk) disable iff (!rst_b)
		(expire && !wr_ans && !leave_reset && (s_r.fail_cnt == 2'h2))
		|=> (s_r.fail_cnt == 2'h3))
		else $error("period overflow not counted");

	// Receive pin stays high outside the low power modes
	a_rxd_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
		((dev_mode != MODE_STANDBY) && (dev_mode != MODE_SLEEP))
		|=> rxd_n)
		else $error("receive pin low outside low power modes");

	// Quiet Standby honours the disable request
	a_off_enter: assert property (@(posedge mclk) disable iff (!rst_b)
		(running && stby_mode && !trig && wr_cfg && req.wdata[CFG_OFF] && (s_r.irq_status == 8'h00)
			&& (irq_set == 8'h00) && !special_boot_sequence)
		|=> (s_r.wst == WD_OFF))
		else $error("disable request not honoured");

endmodule : qa_watchdog
